// file: rtl/fer_pkg.sv
// Constants, carrier types and register map of the fault event recorder
`default_nettype none
package fer_pkg;
  // ===========================================================
  // Window geometry (one sample per quarter-cycle interval)
  localparam int SPC = 4;
  localparam int WIN_SHORT_CYC = 15;
  localparam int WIN_LONG_CYC = 30;
  localparam logic [6:0] WIN_SHORT = 7'(WIN_SHORT_CYC * SPC);
  localparam logic [6:0] WIN_LONG = 7'(WIN_LONG_CYC * SPC);
  localparam logic [4:0] PRE_MIN = 5'h01;
  localparam logic [4:0] PRE_MAX = 5'h1d;
  localparam logic [4:0] PRE_DEFAULT = 5'h04;
  localparam logic [4:0] SLOTS_SHORT = 5'h1c;
  localparam logic [4:0] SLOTS_LONG = 5'h0e;
  localparam logic [6:0] HIST_LAST = 7'h7f;
  localparam logic [8:0] LOG_LAST = 9'h1ff;
  localparam logic [9:0] LOG_DEPTH = 10'h200;
  // ===========================================================
  // Register map (byte offsets) and fields
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_CLEAR = 8'h10;
  localparam logic [7:0] OFF_ENABLE = 8'h14;
  localparam logic [7:0] OFF_INFO = 8'h18;
  localparam int CTRL_LONG_BIT = 0;
  localparam int CTRL_PRE_LSB = 8;
  localparam int CMD_TRIG_BIT = 0;
  localparam int STAT_W = 3;
  localparam int ST_REPORT = 0;
  localparam int ST_LOG = 1;
  localparam int ST_ERASE = 2;
  localparam int INFO_CNT_LSB = 0;
  localparam int INFO_SLOT_LSB = 8;
  localparam int INFO_LOG_LSB = 16;
  localparam int INFO_BUSY_BIT = 31;
  // ===========================================================
  // Carriers
  typedef struct packed {
    logic [31:0] stamp;
    logic [15:0] current;
    logic [15:0] voltage;
    logic [15:0] frequency;
    logic [7:0] elements;
    logic [7:0] inputs;
    logic [7:0] contacts;
    logic [15:0] faultLoc;
  } fer_sample_t;
  typedef struct packed {
    logic we;
    logic [10:0] addr;
    fer_sample_t data;
  } fer_store_wr_t;
  typedef struct packed {
    logic we;
    logic [8:0] addr;
    logic [31:0] stamp;
    logic [15:0] state;
  } fer_log_wr_t;
  typedef enum logic [1:0] {CAP_IDLE, CAP_COPY, CAP_POST} fer_cap_state_t;
endpackage
`default_nettype wire

// file: rtl/fer_ring_ctr.sv
// Wrapping pointer used for the circular stores and the history ring
`default_nettype none
module fer_ring_ctr #(
  parameter int W = 7
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clr,
  input wire logic inc,
  input wire logic [W-1:0] last,
  output logic [W-1:0] value
);
  logic [W-1:0] value_d;
  logic [W-1:0] value_q;

  always_comb begin
    value_d = value_q;
    if (clr) begin
      value_d = '0;
    end else if (inc) begin
      // Newest entry lands on the oldest slot once the store is full
      value_d = (value_q == last) ? '0 : W'(value_q + 1'b1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      value_q <= '0;
    end else begin
      value_q <= value_d;
    end
  end

  assign value = value_q;
endmodule // fer_ring_ctr
`default_nettype wire

// file: rtl/fer_top.sv
// Fault event recorder: report capture, change-of-state log, AHB-Lite registers
// Overview of operation
// - Each report is a fixed window of either 15 or 30 power cycles.
// - The prefault part before the trigger point is settable from 1 to 29 cycles, at most 14 in short reports.
// - The store holds 28 short or 14 long reports and the newest replaces the oldest.
// - Changing the report length erases every stored report.
// - Changing the prefault length leaves stored reports untouched.
// - Defaults are the short report length and a prefault of four cycles.
// - A rising protective trip flag starts a report with no further setup.
// - The programmable trigger equation going to one starts a report.
// - A manual trigger command from the host generates a report.
// - A pulse command on any of the seven main output contacts generates a report.
// - Each report carries time stamp, analog values, element, input, contact and location data.
// - Each change of a monitored condition appends one time-stamped log line.
// - The log keeps the latest 512 lines, overwriting the oldest once full.
// - The equation acts on its rising edge and only when no report already covers it.
`default_nettype none
module fer_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic tripFlag,
  input wire logic programmableTriggerEquation,
  input wire logic [6:0] contactPulseCommand,
  input wire logic sampleValid,
  input wire fer_pkg::fer_sample_t sampleIn,
  input wire logic [15:0] monitorIn,
  input wire logic [31:0] timeStamp,
  output fer_pkg::fer_store_wr_t storeWr,
  output logic storeErase,
  output fer_pkg::fer_log_wr_t stateChangeLog,
  output logic irq
);
  import fer_pkg::*;

  // ===========================================================
  // Declarations
  logic addrPhase, lenChange, trigAny, tripEdge, eqEdge, reportDone, logEv;
  logic dpWr_q, dpWr_d, manual_q, manual_d, lenLong_q, lenLong_d, irq_q, irq_d;
  logic [7:0] dpAddr_q, dpAddr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [4:0] pre_q, pre_d, reportCount_q, reportCount_d, slot, preEff;
  logic [15:0] mask_q, mask_d, mon_q, mon_d;
  logic [STAT_W-1:0] status_q, status_d, irqEn_q, irqEn_d, clr;
  fer_cap_state_t capState_q, capState_d;
  logic [6:0] idx_q, idx_d, rdPtr_q, rdPtr_d, preSamp_q, preSamp_d, histPtr, winSamp;
  logic trip_q, trip_d, eq_q, eq_d, storeErase_q, storeErase_d;
  fer_store_wr_t storeWr_q, storeWr_d;
  fer_sample_t hist_q [0:127];
  fer_sample_t hist_d [0:127];
  fer_log_wr_t logWr_q, logWr_d;
  logic [8:0] logPtr;
  logic [9:0] logCount_q, logCount_d;

  function automatic logic [4:0] clampPre(input logic [4:0] v);
    if (v < PRE_MIN) return PRE_MIN;
    if (v > PRE_MAX) return PRE_MAX;
    return v;
  endfunction

  function automatic logic [10:0] slotAddr(input logic [4:0] s, input logic [6:0] i,
                                           input logic lng);
    return 11'(s) * 11'(lng ? WIN_LONG : WIN_SHORT) + 11'(i);
  endfunction

  // ===========================================================
  // AHB-Lite slave and registers
  always_comb begin
    addrPhase = hsel && htrans[1] && hready;
    dpWr_d = addrPhase && hwrite;
    dpAddr_d = addrPhase ? haddr[7:0] : dpAddr_q;
    hrdata_d = hrdata_q;
    lenLong_d = lenLong_q;
    pre_d = pre_q;
    mask_d = mask_q;
    irqEn_d = irqEn_q;
    manual_d = 1'b0;
    clr = '0;
    lenChange = 1'b0;
    if (addrPhase && !hwrite) begin
      // Read data is registered in the address phase: zero wait states
      hrdata_d = '0;
      case (haddr[7:0])
        OFF_CTRL: begin
          hrdata_d[CTRL_LONG_BIT] = lenLong_q;
          hrdata_d[CTRL_PRE_LSB +: 5] = pre_q;
        end
        OFF_MASK: hrdata_d[15:0] = mask_q;
        OFF_STATUS: hrdata_d[STAT_W-1:0] = status_q;
        OFF_ENABLE: hrdata_d[STAT_W-1:0] = irqEn_q;
        OFF_INFO: begin
          hrdata_d[INFO_CNT_LSB +: 5] = reportCount_q;
          hrdata_d[INFO_SLOT_LSB +: 5] = slot;
          hrdata_d[INFO_LOG_LSB +: 10] = logCount_q;
          hrdata_d[INFO_BUSY_BIT] = (capState_q != CAP_IDLE);
        end
        default: hrdata_d = '0;
      endcase
    end
    if (dpWr_q) begin
      case (dpAddr_q)
        OFF_CTRL: begin
          lenLong_d = hwdata[CTRL_LONG_BIT];
          lenChange = hwdata[CTRL_LONG_BIT] != lenLong_q;
          pre_d = clampPre(hwdata[CTRL_PRE_LSB +: 5]);
        end
        OFF_CMD: manual_d = hwdata[CMD_TRIG_BIT];
        OFF_MASK: mask_d = hwdata[15:0];
        OFF_CLEAR: clr = hwdata[STAT_W-1:0];
        OFF_ENABLE: irqEn_d = hwdata[STAT_W-1:0];
        default: clr = '0;
      endcase
    end
    // Set wins over a clear arriving in the same cycle
    status_d = status_q & ~clr;
    status_d[ST_REPORT] = status_d[ST_REPORT] | reportDone;
    status_d[ST_LOG] = status_d[ST_LOG] | logEv;
    status_d[ST_ERASE] = status_d[ST_ERASE] | lenChange;
    irq_d = |(status_d & irqEn_d);
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dpWr_q <= 1'b0;
      dpAddr_q <= '0;
      hrdata_q <= '0;
      lenLong_q <= 1'b0;
      pre_q <= PRE_DEFAULT;
      mask_q <= '0;
      irqEn_q <= '0;
      manual_q <= 1'b0;
      status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      dpWr_q <= dpWr_d;
      dpAddr_q <= dpAddr_d;
      hrdata_q <= hrdata_d;
      lenLong_q <= lenLong_d;
      pre_q <= pre_d;
      mask_q <= mask_d;
      irqEn_q <= irqEn_d;
      manual_q <= manual_d;
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  // ===========================================================
  // Pointers into the circular stores
  fer_ring_ctr #(.W(5)) u_slot (.core_clk(core_clk), .resetn(resetn), .clr(lenChange),
    .inc(reportDone), .last(lenLong_q ? SLOTS_LONG - 5'h01 : SLOTS_SHORT - 5'h01),
    .value(slot));
  fer_ring_ctr #(.W(7)) u_hist (.core_clk(core_clk), .resetn(resetn), .clr(1'b0),
    .inc(sampleValid), .last(HIST_LAST), .value(histPtr));
  fer_ring_ctr #(.W(9)) u_log (.core_clk(core_clk), .resetn(resetn), .clr(1'b0),
    .inc(logEv), .last(LOG_LAST), .value(logPtr));

  // ===========================================================
  // Report capture
  always_comb begin
    hist_d = hist_q;
    if (sampleValid) begin
      hist_d[histPtr] = sampleIn;
    end
    trip_d = tripFlag;
    eq_d = programmableTriggerEquation;
    tripEdge = tripFlag && !trip_q;
    eqEdge = programmableTriggerEquation && !eq_q;
    trigAny = tripEdge || eqEdge || manual_q || (|contactPulseCommand);
    winSamp = lenLong_q ? WIN_LONG : WIN_SHORT;
    // Prefault never fills the whole window
    preEff = (!lenLong_q && pre_q > 5'(WIN_SHORT_CYC - 1)) ? 5'(WIN_SHORT_CYC - 1) : pre_q;
    capState_d = capState_q;
    idx_d = idx_q;
    rdPtr_d = rdPtr_q;
    preSamp_d = preSamp_q;
    storeWr_d = storeWr_q;
    storeWr_d.we = 1'b0;
    storeErase_d = 1'b0;
    reportDone = 1'b0;
    reportCount_d = reportCount_q;
    case (capState_q)
      CAP_IDLE: begin
        // Triggers while a report is open are covered by it and dropped
        if (trigAny) begin
          capState_d = CAP_COPY;
          idx_d = '0;
          preSamp_d = 7'(preEff * SPC);
          rdPtr_d = 7'(histPtr - 7'(preEff * SPC));
        end
      end
      CAP_COPY: begin
        storeWr_d = '{we: 1'b1, addr: slotAddr(slot, idx_q, lenLong_q),
                      data: hist_q[rdPtr_q]};
        idx_d = 7'(idx_q + 7'h01);
        rdPtr_d = 7'(rdPtr_q + 7'h01);
        if (idx_q == 7'(preSamp_q - 7'h01)) begin
          capState_d = CAP_POST;
        end
      end
      CAP_POST: begin
        if (sampleValid) begin
          storeWr_d = '{we: 1'b1, addr: slotAddr(slot, idx_q, lenLong_q),
                        data: sampleIn};
          idx_d = 7'(idx_q + 7'h01);
          if (idx_q == 7'(winSamp - 7'h01)) begin
            capState_d = CAP_IDLE;
            reportDone = 1'b1;
          end
        end
      end
      default: capState_d = CAP_IDLE;
    endcase
    if (reportDone && reportCount_q < (lenLong_q ? SLOTS_LONG : SLOTS_SHORT)) begin
      reportCount_d = 5'(reportCount_q + 5'h01);
    end
    if (lenChange) begin
      // A half-written report would be meaningless under the new length
      capState_d = CAP_IDLE;
      reportCount_d = '0;
      storeErase_d = 1'b1;
      storeWr_d.we = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      capState_q <= CAP_IDLE;
      idx_q <= '0;
      rdPtr_q <= '0;
      preSamp_q <= '0;
      storeWr_q <= '0;
      storeErase_q <= 1'b0;
      reportCount_q <= '0;
      trip_q <= 1'b0;
      eq_q <= 1'b0;
      hist_q <= '{default: '0};
    end else begin
      capState_q <= capState_d;
      idx_q <= idx_d;
      rdPtr_q <= rdPtr_d;
      preSamp_q <= preSamp_d;
      storeWr_q <= storeWr_d;
      storeErase_q <= storeErase_d;
      reportCount_q <= reportCount_d;
      trip_q <= trip_d;
      eq_q <= eq_d;
      hist_q <= hist_d;
    end
  end

  // ===========================================================
  // Change-of-state log
  always_comb begin
    mon_d = monitorIn;
    logEv = |((monitorIn ^ mon_q) & mask_q);
    logWr_d = logWr_q;
    logWr_d.we = 1'b0;
    logCount_d = logCount_q;
    if (logEv) begin
      logWr_d = '{we: 1'b1, addr: logPtr, stamp: timeStamp, state: monitorIn};
      if (logCount_q < LOG_DEPTH) begin
        logCount_d = 10'(logCount_q + 10'h001);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mon_q <= '0;
      logWr_q <= '0;
      logCount_q <= '0;
    end else begin
      mon_q <= mon_d;
      logWr_q <= logWr_d;
      logCount_q <= logCount_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign storeWr = storeWr_q;
  assign storeErase = storeErase_q;
  assign stateChangeLog = logWr_q;
  assign irq = irq_q;

  // ===========================================================
  // Checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_trip_start: assert property (tripEdge && capState_q == CAP_IDLE && !lenChange
    |=> capState_q == CAP_COPY) else $error("trip did not start report");
  a_eq_start: assert property (eqEdge && capState_q == CAP_IDLE && !lenChange
    |=> capState_q == CAP_COPY) else $error("equation did not start report");
  a_manual_start: assert property (manual_q && capState_q == CAP_IDLE && !lenChange
    |=> capState_q == CAP_COPY && idx_q == 7'h00) else $error("manual miss");
  a_pulse_start: assert property ((|contactPulseCommand) && capState_q == CAP_IDLE
    && !lenChange |=> capState_q == CAP_COPY) else $error("pulse miss");
  a_busy_ignore: assert property (capState_q == CAP_POST && trigAny && !reportDone
    && !lenChange |=> capState_q == CAP_POST) else $error("retrigger while busy");
  a_len_erase: assert property (lenChange |=> storeErase_q && reportCount_q == 5'h00
    && capState_q == CAP_IDLE && slot == 5'h00) else $error("length change kept reports");
  a_pre_keep: assert property (dpWr_q && dpAddr_q == OFF_CTRL && !lenChange
    |=> !storeErase_q && reportCount_q >= $past(reportCount_q)) else $error("pre erased");
  a_reset_defaults: assert property ($rose(resetn) |-> !lenLong_q
    && pre_q == PRE_DEFAULT) else $error("bad defaults");
  a_store_limit: assert property (reportCount_q <= (lenLong_q ? SLOTS_LONG : SLOTS_SHORT)
    && slot < (lenLong_q ? SLOTS_LONG : SLOTS_SHORT)) else $error("store overrun");
  a_window_len: assert property (capState_q != CAP_IDLE |-> idx_q < winSamp)
    else $error("window overrun");
  a_pre_copy: assert property (capState_q == CAP_COPY && idx_q == 7'(preSamp_q - 7'h01)
    && !lenChange |=> capState_q == CAP_POST && storeWr_q.we
    && preSamp_q >= 7'(SPC)) else $error("prefault copy length");
  a_post_data: assert property (capState_q == CAP_POST && sampleValid && !lenChange
    |=> storeWr_q.we && storeWr_q.data == $past(sampleIn)) else $error("sample lost");
  a_log_line: assert property (logEv |=> stateChangeLog.we
    && stateChangeLog.addr == $past(logPtr)) else $error("log line missing");
  a_log_wrap: assert property (logEv && logPtr == LOG_LAST |=> logPtr == 9'h000)
    else $error("log did not wrap");
  a_hist_roll: assert property (sampleValid |=> histPtr == 7'($past(histPtr) + 7'h01))
    else $error("history stalled");

  c_report_done: cover property (capState_q == CAP_POST ##1 capState_q == CAP_IDLE);
  c_len_erase: cover property (lenChange);
  c_busy_trigger: cover property (capState_q == CAP_POST && trigAny);
  c_log_wrap: cover property (logEv && logPtr == LOG_LAST);
endmodule // fer_top
`default_nettype wire

// file: tb/fer_partner.sv
// Protection logic and command side model driving the recorder inputs
`default_nettype none
module fer_partner (
  input wire logic core_clk,
  output logic tripFlag,
  output logic programmableTriggerEquation,
  output logic [6:0] contactPulseCommand,
  output logic sampleValid,
  output fer_pkg::fer_sample_t sampleIn,
  output logic [15:0] monitorIn,
  output logic [31:0] timeStamp
);
  timeunit 1ns;
  timeprecision 1ns;
  import fer_pkg::*;
  int gap;
  initial begin
    gap = 0;
    tripFlag = 1'b0;
    programmableTriggerEquation = 1'b0;
    contactPulseCommand = 7'h00;
    sampleValid = 1'b0;
    sampleIn = '{32'h0, 16'h0123, 16'h4567, 16'h0e10, 8'h11, 8'h22, 8'h44, 16'h0100};
    monitorIn = 16'h0000;
    timeStamp = 32'h00000000;
  end
  // ==========
  // Interval samples, spaced wider than the capture copy phase
  always @(posedge core_clk) begin
    gap <= (gap == 129) ? 0 : gap + 1;
    sampleValid <= (gap == 129);
    if (gap == 129) begin
      sampleIn.stamp <= sampleIn.stamp + 32'h1;
      sampleIn.faultLoc <= sampleIn.faultLoc ^ 16'h5a5a;
    end
  end
  // ==========
  // One-clock-cycle trigger pulses and monitor input updates
  task automatic pulseTrip();
    @(posedge core_clk);
    tripFlag <= 1'b1;
    @(posedge core_clk);
    tripFlag <= 1'b0;
  endtask
  task automatic pulseEq();
    @(posedge core_clk);
    programmableTriggerEquation <= 1'b1;
    @(posedge core_clk);
    programmableTriggerEquation <= 1'b0;
  endtask
  task automatic pulseContact(input int k);
    @(posedge core_clk);
    contactPulseCommand <= 7'(1 << k);
    @(posedge core_clk);
    contactPulseCommand <= 7'h00;
  endtask
  task automatic setMon(input logic [15:0] v, input logic [31:0] t);
    @(posedge core_clk);
    monitorIn <= v;
    timeStamp <= t;
  endtask
endmodule  // fer_partner
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the fault event recorder
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fer_pkg::*;
  logic core_clk, resetn, hsel, hwrite, hready, hreadyout, hresp, irq, storeErase;
  logic tripFlag, programmableTriggerEquation, sampleValid;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, timeStamp;
  logic [6:0] contactPulseCommand;
  logic [15:0] monitorIn;
  fer_sample_t sampleIn;
  fer_store_wr_t storeWr;
  fer_log_wr_t stateChangeLog;
  int checks = 0, bad_count = 0, cyc = 0, eraseCount = 0;
  assign hready = hreadyout;
  fer_top dut_u (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tripFlag(tripFlag),
    .programmableTriggerEquation(programmableTriggerEquation),
    .contactPulseCommand(contactPulseCommand), .sampleValid(sampleValid),
    .sampleIn(sampleIn), .monitorIn(monitorIn), .timeStamp(timeStamp), .storeWr(storeWr),
    .storeErase(storeErase), .stateChangeLog(stateChangeLog), .irq(irq));
  fer_partner partner_u (.core_clk(core_clk), .tripFlag(tripFlag),
    .programmableTriggerEquation(programmableTriggerEquation),
    .contactPulseCommand(contactPulseCommand), .sampleValid(sampleValid),
    .sampleIn(sampleIn), .monitorIn(monitorIn), .timeStamp(timeStamp));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  always @(negedge core_clk) begin
    if (storeErase === 1'b1) eraseCount++;
  end
  // ==========
  // Shared helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) chk("hready", 32'h1, 32'h0);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic ahbWr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    chk(what, exp, d);
  endtask
  function automatic logic [31:0] info(input int cnt, input int slot, input int logs);
    return 32'((cnt << INFO_CNT_LSB) | (slot << INFO_SLOT_LSB) | (logs << INFO_LOG_LSB));
  endfunction
  // Follows one whole window, then makes sure nothing more is written
  task automatic expectReport(input int base, input int total, input int pre);
    int n, start;
    @(negedge core_clk);
    for (int i = 0; i < total; i++) begin
      n = 0;
      while (storeWr.we !== 1'b1 && n < 400) begin
        @(negedge core_clk);
        n++;
      end
      if (i == 0) start = cyc;
      if (i < pre) chk("copyCycle", 32'(start + i), 32'(cyc));
      chk("storeAddr", 32'(base + i), {21'h0, storeWr.addr});
      if (i == pre) chk("postStamp", sampleIn.stamp, storeWr.data.stamp);
      @(negedge core_clk);
    end
    n = 0;
    repeat (150) begin
      @(negedge core_clk);
      if (storeWr.we === 1'b1) n++;
    end
    chk("extraWrites", 32'h0, 32'(n));
  endtask
  // ==========
  // Scenarios
  task automatic testDefaults();
    rdChk(OFF_CTRL, 32'(PRE_DEFAULT) << CTRL_PRE_LSB, "ctrl");
    rdChk(OFF_INFO, 32'h0, "info");
    ahbWr(8'h1c, 32'hffffffff);
    rdChk(8'h1c, 32'h0, "unmapped");
    rdChk(OFF_STATUS, 32'h0, "status");
  endtask
  task automatic testManual();
    ahbWr(OFF_ENABLE, 32'h1 << ST_REPORT);
    ahbWr(OFF_CMD, 32'h1 << CMD_TRIG_BIT);
    expectReport(0, WIN_SHORT, PRE_DEFAULT * SPC);
    chk("irqOn", 32'h1, {31'h0, irq});
    ahbWr(OFF_CLEAR, 32'h1 << ST_REPORT);
    repeat (2) @(negedge core_clk);
    chk("irqOff", 32'h0, {31'h0, irq});
    rdChk(OFF_INFO, info(1, 1, 0), "info");
  endtask
  task automatic testTripAndEq();
    ahbWr(OFF_ENABLE, 32'h0);
    partner_u.pulseTrip();
    expectReport(60, WIN_SHORT, PRE_DEFAULT * SPC);
    chk("irqMasked", 32'h0, {31'h0, irq});
    rdChk(OFF_STATUS, 32'h1 << ST_REPORT, "status");
    partner_u.pulseEq();
    fork
      expectReport(120, WIN_SHORT, PRE_DEFAULT * SPC);
      begin
        repeat (30) @(posedge core_clk);
        partner_u.pulseEq();
        rdChk(OFF_INFO, info(2, 2, 0) | (32'h1 << INFO_BUSY_BIT), "infoBusy");
      end
    join
    rdChk(OFF_INFO, info(3, 3, 0), "info");
  endtask
  task automatic testPrefaultAndContacts();
    int e0;
    e0 = eraseCount;
    ahbWr(OFF_CTRL, 32'h1d << CTRL_PRE_LSB);
    rdChk(OFF_CTRL, 32'h1d << CTRL_PRE_LSB, "ctrl");
    rdChk(OFF_INFO, info(3, 3, 0), "info");
    chk("eraseCount", 32'(e0), 32'(eraseCount));
    // Short window leaves room for at most 14 prefault cycles
    for (int k = 0; k < 7; k++) begin
      partner_u.pulseContact(k);
      expectReport((3 + k) * 60, WIN_SHORT, (WIN_SHORT_CYC - 1) * SPC);
    end
    rdChk(OFF_INFO, info(10, 10, 0), "info");
  endtask
  task automatic testLengthAndWrap();
    int e0;
    e0 = eraseCount;
    ahbWr(OFF_CTRL, (32'h1d << CTRL_PRE_LSB) | 32'h1);
    repeat (3) @(negedge core_clk);
    chk("eraseCount", 32'(e0 + 1), 32'(eraseCount));
    rdChk(OFF_INFO, info(0, 0, 0), "info");
    rdChk(OFF_STATUS, (32'h1 << ST_REPORT) | (32'h1 << ST_ERASE), "status");
    for (int r = 0; r < 15; r++) begin
      ahbWr(OFF_CMD, 32'h1 << CMD_TRIG_BIT);
      expectReport((r % 14) * 120, WIN_LONG, 116);
    end
    rdChk(OFF_INFO, info(14, 1, 0), "info");
  endtask
  task automatic testLog();
    logic [15:0] mon;
    int n;
    ahbWr(OFF_MASK, 32'h1);
    rdChk(OFF_MASK, 32'h1, "mask");
    mon = 16'h0002;
    partner_u.setMon(mon, 32'h0);
    repeat (4) @(negedge core_clk);
    rdChk(OFF_STATUS, (32'h1 << ST_REPORT) | (32'h1 << ST_ERASE), "status");
    for (int i = 0; i < 513; i++) begin
      mon ^= 16'h0001;
      partner_u.setMon(mon, 32'ha000 + 32'(i));
      n = 0;
      do begin
        @(negedge core_clk);
        n++;
      end while (stateChangeLog.we !== 1'b1 && n < 5);
      chk("logAddr", 32'(i % 512), {23'h0, stateChangeLog.addr});
      chk("logStamp", 32'ha000 + 32'(i), stateChangeLog.stamp);
      chk("logState", {16'h0, mon}, {16'h0, stateChangeLog.state});
    end
    rdChk(OFF_INFO, info(14, 1, 512), "info");
    rdChk(OFF_STATUS, (32'h1 << ST_REPORT) | (32'h1 << ST_LOG) | (32'h1 << ST_ERASE),
      "statusAll");
    ahbWr(OFF_CLEAR, (32'h1 << ST_REPORT) | (32'h1 << ST_LOG) | (32'h1 << ST_ERASE));
    rdChk(OFF_STATUS, 32'h0, "statusClr");
  endtask
  // ==========
  // Run control
  task automatic conclude();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    testDefaults();
    testManual();
    testTripAndEq();
    testPrefaultAndContacts();
    testLengthAndWrap();
    testLog();
    conclude();
  end
  // Roughly twice the expected run length
  initial begin
    #8000000;
    bad_count++;
    conclude();
  end
endmodule  // tb_top
`default_nettype wire
